// [cfg_i2c_target.sv]
// I2C target serving volatile configuration registers and their stored copy.
// Assumes open-drain bus lines resolved outside; clk_i far faster than SCL.
module cfg_i2c_target import cfg_port_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // I2C pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Protection
   input wire logic wp_i,
   input wire logic wp_enable_i,
   // Status
   output logic save_busy_o,
   output logic [7:0] nvm_transfer_select_o
);
   // ****************************************
   // Pin conditioning
   // ****************************************
   bus_pins_t lvl;
   bus_events_t ev;
   logic wp_meta_q, wp_q;
   bus_pins_t pins_raw;
   assign pins_raw = '{scl: scl_i, sda: sda_i};
   // Oversampling at the system clock serves standard and fast bus rates alike
   cfg_pin_sync u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pins_i(pins_raw),
      .level_o(lvl),
      .ev_o(ev)
   );
   always_ff @(posedge clk_i) begin
      wp_meta_q <= sys_rst_i ? 1'b1 : wp_i;
      wp_q <= sys_rst_i ? 1'b1 : wp_meta_q;
   end
   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] vol_q [NUM_REGS];
   logic [7:0] nvm_q [NUM_REGS];
   logic [IDX_W-1:0] xfer_q;
   logic loading_q, saving_q;
   logic [7:0] sel_q;
   // ****************************************
   // Bus state
   // ****************************************
   bus_state_t st_q;
   logic [7:0] shift_q;
   logic [3:0] bit_q;
   logic [7:0] idx_q;
   logic got_idx_q, rd_q;
   logic sda_oe_q;
   // A save is not in blocked: it refuses new starts and drops writes, so the save command byte is still acknowledged
   wire blocked = (wp_q && wp_enable_i) || loading_q;
   wire [7:0] rx_byte = {shift_q[6:0], lvl.sda};
   wire last_bit = bit_q == 4'd7;
   wire addr_hit = rx_byte[7:1] == TARGET_ADDR;
   wire in_range = idx_q <= LAST_INDEX;
   wire [IDX_W-1:0] idx_lo = idx_q[IDX_W-1:0];
   wire [7:0] rd_vol = in_range ? vol_q[idx_lo] : 8'h00;
   wire [7:0] rd_nvm = in_range ? nvm_q[idx_lo] : 8'h00;
   wire [7:0] rd_src = (idx_q == CTRL_INDEX) ? sel_q :
                       (sel_q == CMD_READ_STORED) ? rd_nvm : rd_vol;
   wire data_rx = (st_q == ST_WRITE) && ev.rise && last_bit;
   wire data_store = data_rx && got_idx_q;
   wire ctrl_wr = data_store && idx_q == CTRL_INDEX;
   wire [7:0] nxt_idx = idx_q + 8'h01;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || blocked || ev.stop) begin
         st_q <= ST_IDLE;
         sda_oe_q <= 1'b0;
         bit_q <= 4'd0;
      end else if (ev.start) begin
         // Repeated start keeps the index
         st_q <= saving_q ? ST_IDLE : ST_ADDR;
         bit_q <= 4'd0;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: ;
            ST_ADDR: if (ev.rise) begin
               shift_q <= rx_byte;
               bit_q <= bit_q + 4'd1;
               if (last_bit) begin
                  if (addr_hit) begin
                     st_q <= ST_ADDR_ACK;
                     rd_q <= rx_byte[0];
                     got_idx_q <= 1'b0;
                  end else begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK, ST_WRITE_ACK: if (ev.fall) begin
               if (!sda_oe_q) begin
                  sda_oe_q <= 1'b1;
               end else begin
                  sda_oe_q <= rd_q ? !rd_src[7] : 1'b0;
                  shift_q <= rd_src;
                  bit_q <= 4'd0;
                  st_q <= rd_q ? ST_READ : ST_WRITE;
               end
            end
            ST_WRITE: if (ev.rise) begin
               shift_q <= rx_byte;
               bit_q <= bit_q + 4'd1;
               if (last_bit) begin
                  st_q <= ST_WRITE_ACK;
                  if (!got_idx_q) begin
                     idx_q <= rx_byte;
                     got_idx_q <= 1'b1;
                  end else begin
                     idx_q <= nxt_idx;
                  end
               end
            end
            ST_READ: if (ev.fall) begin
               bit_q <= bit_q + 4'd1;
               shift_q <= {shift_q[6:0], 1'b0};
               sda_oe_q <= last_bit ? 1'b0 : !shift_q[6];
               if (last_bit) begin
                  st_q <= ST_READ_ACK;
               end
            end
            ST_READ_ACK: if (ev.rise) begin
               if (lvl.sda) begin
                  st_q <= ST_IDLE;
               end else begin
                  idx_q <= nxt_idx;
                  st_q <= ST_ADDR_ACK;
                  sda_oe_q <= 1'b1; // Skip the ack drive, load next byte on fall
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   // ****************************************
   // Register writes, load and save
   // ****************************************
   // Stored copy has no reset values; the load after reset copies it as it stands
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sel_q <= NVM_SELECT_RESET;
         loading_q <= 1'b1;
         saving_q <= 1'b0;
         xfer_q <= '0;
      end else if (loading_q || saving_q) begin
         if (loading_q) begin
            vol_q[xfer_q] <= nvm_q[xfer_q];
         end else begin
            nvm_q[xfer_q] <= vol_q[xfer_q];
         end
         xfer_q <= xfer_q + IDX_W'(1);
         if (xfer_q == IDX_W'(NUM_REGS - 1)) begin
            loading_q <= 1'b0;
            saving_q <= 1'b0;
            xfer_q <= '0;
         end
      end else if (ctrl_wr) begin
         if (rx_byte == CMD_SAVE) begin
            saving_q <= 1'b1;
         end else begin
            sel_q <= rx_byte;
         end
      end else if (data_store && in_range) begin
         vol_q[idx_lo] <= rx_byte;
      end
   end
   assign sda_o = 1'b0;
   always_ff @(posedge clk_i) begin
      sda_oe_o <= sys_rst_i ? 1'b0 : sda_oe_q;
      save_busy_o <= sys_rst_i ? 1'b0 : saving_q;
      nvm_transfer_select_o <= sys_rst_i ? NVM_SELECT_RESET : sel_q;
   end
   // ****************************************
   // Checks
   // ****************************************
   a_block_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      blocked |=> st_q == ST_IDLE) else $error("traffic served while blocked");
   a_index_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (data_store && !blocked && !ev.stop && !ev.start) |=> idx_q == $past(idx_q) + 8'h01)
      else $error("index did not advance");
   a_save_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_wr && !blocked && rx_byte == CMD_SAVE) |=> saving_q)
      else $error("save not started");
   a_no_save: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_wr && !blocked && rx_byte != CMD_SAVE) |=> !saving_q && sel_q == $past(rx_byte))
      else $error("select not taken");
   a_save_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(saving_q) |-> saving_q [*8] ##13 !saving_q) else $error("save length");
   a_sel_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !$past(ctrl_wr) |-> $stable(sel_q)) else $error("select changed");
   a_nack_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_q == ST_READ_ACK && ev.rise && lvl.sda && !blocked && !ev.stop && !ev.start)
      |=> !sda_oe_q && st_q == ST_IDLE) else $error("line held after nack");
   a_wrong_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_q == ST_ADDR && ev.rise && last_bit && !addr_hit && !blocked && !ev.stop
      && !ev.start) |=> st_q == ST_IDLE) else $error("foreign address taken");
   c_save: cover property (@(posedge clk_i) $rose(saving_q));
   c_read: cover property (@(posedge clk_i) st_q == ST_READ_ACK && ev.rise && !lvl.sda);
   c_write: cover property (@(posedge clk_i) data_store && idx_q < LAST_INDEX);
endmodule // cfg_i2c_target

// [cfg_pin_sync.sv]
// Two-stage synchroniser plus edge/condition detector for the I2C pins.
// Assumes pins are asynchronous to clk_i.
module cfg_pin_sync import cfg_port_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Pins
   input wire bus_pins_t pins_i,
   // Decoded
   output bus_pins_t level_o,
   output bus_events_t ev_o
);
   bus_pins_t meta_q;
   bus_pins_t sync_q;
   bus_pins_t prev_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_q <= '{scl: 1'b1, sda: 1'b1};
         sync_q <= '{scl: 1'b1, sda: 1'b1};
         prev_q <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         meta_q <= pins_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign level_o = sync_q;
   assign ev_o.start = sync_q.scl && prev_q.scl && prev_q.sda && !sync_q.sda;
   assign ev_o.stop = sync_q.scl && prev_q.scl && !prev_q.sda && sync_q.sda;
   assign ev_o.rise = sync_q.scl && !prev_q.scl;
   assign ev_o.fall = !sync_q.scl && prev_q.scl;
endmodule // cfg_pin_sync

// [cfg_port_pkg.sv]
// Package for the configuration-register I2C target port.
// Assumes a single 50 MHz clock domain; bus pins are sampled asynchronously.
package cfg_port_pkg;
   // ****************************************
   // Bus addressing
   // ****************************************
   localparam logic [6:0] TARGET_ADDR = 7'h74;
   localparam logic [7:0] CTRL_INDEX = 8'hFF;
   localparam logic [7:0] CMD_SAVE = 8'h80;
   localparam logic [7:0] CMD_READ_VOLATILE = 8'h00;
   localparam logic [7:0] CMD_READ_STORED = 8'h01;
   // ****************************************
   // Register file
   // ****************************************
   localparam int NUM_REGS = 20;
   localparam int IDX_W = 5;
   localparam logic [7:0] LAST_INDEX = 8'h13;
   localparam logic [7:0] NVM_SELECT_RESET = 8'h00;
   // Save takes one cycle per register; time is in clock cycles
   localparam int CLK_MHZ = 50;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WRITE = 3'b011,
      ST_WRITE_ACK = 3'b100,
      ST_READ = 3'b101,
      ST_READ_ACK = 3'b110
   } bus_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } bus_events_t;
endpackage

// [i2c_host_model.sv]
// Behavioural I2C bus master that drives the clock line and the data line.
// Assumes pull-ups on both lines; the device pulls data low through its enable.
module i2c_host_model (
   // Device side
   input wire logic sda_oe_i,
   // Bus lines
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Bus phases
   // ****************************************
   // Quarter of the 160 ns bus clock; the port answers within 70 ns of a falling edge
   localparam int Q = 40;
   logic drv_low = 1'b0;
   // Wired-AND with pull-up: a released line reads high, never the last value
   assign sda_o = !(drv_low || sda_oe_i);
   initial scl_o = 1'b1;
   task automatic bit_io(input logic b, output logic r);
      drv_low = !b;
      #Q scl_o = 1'b1;
      #Q r = sda_o;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   // Also serves as the repeated start between index and read phase
   task automatic start_cond();
      drv_low = 1'b0;
      #Q scl_o = 1'b1;
      #Q drv_low = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic stop_cond();
      drv_low = 1'b1;
      #Q scl_o = 1'b1;
      #Q drv_low = 1'b0;
      #(2 * Q);
   endtask
   // A high ack_in leaves the byte unacknowledged
   task automatic xfer(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ack_in, ack);
   endtask
endmodule // i2c_host_model

// [test_i2c_config_ram_eeprom_port.sv]
// Self-checking bench for the configuration-register I2C target port.
// Assumes the host model drives the bus lines; registers reached over I2C only.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_i2c_config_ram_eeprom_port import cfg_port_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Harness
   // ****************************************
   typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
   localparam logic [7:0] WR_ADDR = {TARGET_ADDR, 1'b0};
   localparam logic [7:0] RD_ADDR = {TARGET_ADDR, 1'b1};
   logic clk_i = 1'b0, sys_rst_i = 1'b1, wp_i = 1'b0, wp_enable_i = 1'b0;
   logic scl, sda, sda_oe, save_busy, a;
   logic [7:0] sel, q;
   logic [7:0] wq[$], eq[$];
   int fails = 0, total_checks = 0, cycles = 0, busy_cnt = 0, n0 = 0;
   row_t rows[4] = '{'{8'h00, 8'ha5, 8'ha5}, '{8'h13, 8'h3c, 8'h3c},
                     '{8'h14, 8'h77, 8'h00}, '{8'hff, 8'h00, 8'h00}};
   cfg_i2c_target u_cfg_i2c_target (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .wp_i(wp_i),
      .wp_enable_i(wp_enable_i), .save_busy_o(save_busy), .nvm_transfer_select_o(sel));
   i2c_host_model u_i2c_host_model (.sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   always #10 clk_i = !clk_i;
   // Whole run needs about 6200 cycles; the ceiling leaves ample margin
   always @(posedge clk_i) begin
      cycles++;
      if (save_busy === 1'b1) busy_cnt++;
      if (cycles == 20000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic addr(input logic [7:0] b, input logic exp_ack);
      u_i2c_host_model.start_cond();
      u_i2c_host_model.xfer(b, 1'b1, q, a);
      `CHK(a, exp_ack)
   endtask
   task automatic wr(input logic [7:0] idx);
      addr(WR_ADDR, 1'b0);
      u_i2c_host_model.xfer(idx, 1'b1, q, a);
      `CHK(a, 1'b0)
      foreach (wq[i]) begin
         u_i2c_host_model.xfer(wq[i], 1'b1, q, a);
         `CHK(a, 1'b0)
      end
      u_i2c_host_model.stop_cond();
   endtask
   task automatic rd(input logic [7:0] idx);
      addr(WR_ADDR, 1'b0);
      u_i2c_host_model.xfer(idx, 1'b1, q, a);
      addr(RD_ADDR, 1'b0);
      foreach (eq[i]) begin
         u_i2c_host_model.xfer(8'hff, i == eq.size() - 1, q, a);
         `CHK(q, eq[i])
      end
      u_i2c_host_model.stop_cond();
   endtask
   task automatic ctl(input logic [7:0] v);
      wq = '{v};
      wr(CTRL_INDEX);
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (19) @(negedge clk_i);
      `CHK({sda_oe, save_busy, sel}, 10'h000)
      @(negedge clk_i) sys_rst_i = 1'b0;
      repeat (30) @(negedge clk_i);
      $display("test reset done");
      foreach (rows[i]) begin
         wq = '{rows[i].wd};
         wr(rows[i].idx);
         eq = '{rows[i].rd};
         rd(rows[i].idx);
      end
      $display("test table done");
      // Burst runs past the last register; the overflow byte is dropped
      wq = '{8'h22, 8'h33, 8'h44, 8'h55};
      wr(8'h11);
      eq = '{8'h22, 8'h33, 8'h44, 8'h00};
      rd(8'h11);
      addr(8'h50, 1'b1);
      u_i2c_host_model.stop_cond();
      $display("test burst done");
      n0 = busy_cnt;
      ctl(CMD_SAVE);
      `CHK(save_busy, 1'b1)
      `CHK(sel, CMD_READ_VOLATILE)
      for (int n = 0; n < 100 && save_busy; n++) @(negedge clk_i);
      `CHK(save_busy, 1'b0)
      `CHK(busy_cnt - n0, NUM_REGS)
      wq = '{8'h5a};
      wr(8'h00);
      ctl(CMD_READ_STORED);
      `CHK(sel, CMD_READ_STORED)
      eq = '{8'ha5};
      rd(8'h00);
      eq = '{8'h22, 8'h33, 8'h44};
      rd(8'h11);
      eq = '{CMD_READ_STORED};
      rd(CTRL_INDEX);
      ctl(CMD_READ_VOLATILE);
      eq = '{8'h5a};
      rd(8'h00);
      $display("test save done");
      wp_i = 1'b1;
      wp_enable_i = 1'b1;
      repeat (5) @(negedge clk_i);
      addr(WR_ADDR, 1'b1);
      u_i2c_host_model.stop_cond();
      wp_enable_i = 1'b0;
      addr(WR_ADDR, 1'b0);
      u_i2c_host_model.stop_cond();
      wp_i = 1'b0;
      $display("test protect done");
      sys_rst_i = 1'b1;
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (30) @(negedge clk_i);
      eq = '{8'ha5};
      rd(8'h00);
      $display("test reload done");
      end_of_test();
   end
endmodule // test_i2c_config_ram_eeprom_port
